// ### design/dio_defs.vh
// constants for the digital i/o modbus register bank
// assumes a 10 MHz system clock; included by bare name
`ifndef DIO_DEFS_VH
`define DIO_DEFS_VH

// coil space, write side
`define DIO_CO_OUT        16'h0000
`define DIO_CO_CLR_HI     16'h0020
`define DIO_CO_CLR_LO     16'h0021
`define DIO_CO_CLR_CNT    16'h0022
`define DIO_CO_SAVE       16'h003c
`define DIO_CO_PWM_EN     16'h0064
`define DIO_CO_LATCH_EN   16'h0096
`define DIO_CO_CNT_EN     16'h0097
`define DIO_CO_FREQ_EN    16'h00be
`define DIO_CO_POWERON    16'h00eb
`define DIO_CO_SAFE       16'h010b

// discrete input space
`define DIO_DI_STATUS     16'h0000
`define DIO_DI_HI_LATCH   16'h0020
`define DIO_DI_LO_LATCH   16'h0040

// input register space
`define DIO_IR_COUNTER    16'h0010
`define DIO_IR_FREQ       16'h0040
`define DIO_IR_N_DI       16'h0064
`define DIO_IR_N_DO       16'h006e
`define DIO_IR_N_CNT      16'h0079

// reset values of the configuration coils
`define DIO_RST_PWM_EN    1'b0
`define DIO_RST_LATCH_EN  1'b0
`define DIO_RST_CNT_EN    1'b0
`define DIO_RST_FREQ_EN   1'b0
`define DIO_RST_POWERON   1'b0
`define DIO_RST_SAFE      1'b0

// timing
`define DIO_CLK_NS        100
`define DIO_MS_NS         1000000
`define DIO_SEC_NS        1000000000
`define DIO_WDT_MIN_S     16'h0005
`define DIO_FREQ_SCALE    32'h000003e8

`endif

// ### design/dio_modbus_map.v
// register bank of an ethernet digital i/o module, modbus view:
// coils, discrete inputs and input registers on three request ports.
// assumes the protocol engine runs on clk_sys and presents one access
// per strobe; flash storage lives outside and talks over pulses.
//
// Overview of operation
// - writing 1 at coil 0x20 clears every high latch.
// - writing 1 at coil 0x21 clears every low latch.
// - writing 1 at coil 0x22 plus n zeroes counter n.
// - writing 1 at coil 0x3c requests a flash save of command-saved data.
// - command-saved data goes to flash only on the save coil.
// - every write to a flash-backed coil requests an automatic flash record.
// - coils from 0x64 enable pwm per output, reset 0.
// - coil 0x96 enables high and low latching on all inputs, reset 0.
// - coils from 0x97 enable each input's counter, reset 0.
// - coils from 0xbe enable each input's frequency measurement, reset 0.
// - coils from 0xeb hold each output's power-up state, reset 0.
// - coils from 0x10b hold each output's safe state, reset 0.
// - host silence beyond watchdog period forces safe state on outputs without pwm, counts event.
// - discrete inputs from 0 show each input's live level.
// - discrete inputs 0x20 and 0x40 show sticky high and low latches.
// - input registers from 0x10 give each channel's 32-bit counter.
// - each 32-bit value spans two 16-bit registers, channel n at base+2n.
// - frequency times 1000 as 32 bits from 0x40; host divides.
// - registers 0x64, 0x6e, 0x79 give input, output, counter totals.
`include "dio_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module dio_modbus_map #(
  parameter N_DI       = 6,
  parameter N_DO       = 6,
  parameter MS_CYCLES  = `DIO_MS_NS / `DIO_CLK_NS,
  parameter SEC_CYCLES = `DIO_SEC_NS / `DIO_CLK_NS
) (
  input  wire              clk_sys,
  input  wire              rst,
  input  wire              coil_wr,
  input  wire              coil_rd,
  input  wire [15:0]       coil_addr,
  input  wire              coil_wdata,
  output reg               coil_rdata_r,
  output reg               coil_rvalid_r,
  input  wire              di_rd,
  input  wire [15:0]       di_addr,
  output reg               di_rdata_r,
  output reg               di_rvalid_r,
  input  wire              ir_rd,
  input  wire [15:0]       ir_addr,
  output reg  [15:0]       ir_rdata_r,
  output reg               ir_rvalid_r,
  input  wire [N_DI-1:0]   din,
  output wire [N_DO-1:0]   dout,
  input  wire [16*N_DO-1:0] pwm_high_ms,
  input  wire [16*N_DO-1:0] pwm_low_ms,
  input  wire              host_activity,
  input  wire [15:0]       host_link_watchdog_s,
  output reg  [15:0]       wdt_event_count_r,
  output reg               flash_save_req_r,
  output reg               flash_auto_req_r,
  input  wire              flash_restore,
  input  wire              flash_latch_en,
  input  wire [N_DI-1:0]   flash_cnt_en,
  input  wire [N_DI-1:0]   flash_freq_en,
  input  wire [N_DO-1:0]   flash_poweron,
  input  wire [N_DO-1:0]   flash_safe,
  output reg               cfg_latch_en_r,
  output reg  [N_DI-1:0]   cfg_cnt_en_r,
  output reg  [N_DI-1:0]   cfg_freq_en_r,
  output reg  [N_DO-1:0]   cfg_poweron_r,
  output reg  [N_DO-1:0]   cfg_safe_r
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function hit;
    input [15:0] a;
    input [15:0] base;
    input [31:0] k;
    reg   [31:0] s;
    begin
      s = {16'h0000, base} + k;
      hit = ({16'h0000, a} == s);
    end
  endfunction

  function hit_any;
    input [15:0] a;
    input [15:0] base;
    input [31:0] n;
    begin
      hit_any = (a >= base) && ({16'h0000, a} < {16'h0000, base} + n);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  reg  [N_DI-1:0] din_s1_r;
  reg  [N_DI-1:0] din_s2_r;
  reg  [N_DI-1:0] din_prev_r;
  reg  [N_DO-1:0] out_state_r;
  reg  [N_DO-1:0] pwm_en_r;
  reg  [N_DO-1:0] pwm_phase_r;
  reg  [15:0]     pwm_cnt_r [0:N_DO-1];
  reg  [N_DI-1:0] hi_latch_r;
  reg  [N_DI-1:0] lo_latch_r;
  reg  [31:0]     cnt_r [0:N_DI-1];
  reg  [31:0]     freq_acc_r [0:N_DI-1];
  reg  [31:0]     freq_val_r [0:N_DI-1];
  reg  [31:0]     ms_div_r;
  reg  [31:0]     gate_div_r;
  reg  [31:0]     sec_div_r;
  reg  [16:0]     wdt_sec_r;
  reg             wdt_tripped_r;

  wire [N_DI-1:0] rise = din_s2_r & ~din_prev_r;
  wire            ms_tick = (ms_div_r == MS_CYCLES - 1);
  wire            gate_end = (gate_div_r == SEC_CYCLES - 1);
  wire            sec_tick = (sec_div_r == SEC_CYCLES - 1);
  wire            wdt_on = (host_link_watchdog_s >= `DIO_WDT_MIN_S);
  wire            wdt_fire = wdt_on && !wdt_tripped_r &&
                             (wdt_sec_r > {1'b0, host_link_watchdog_s});
  wire            wr_clr_hi = coil_wr && coil_wdata &&
                              (coil_addr == `DIO_CO_CLR_HI);
  wire            wr_clr_lo = coil_wr && coil_wdata &&
                              (coil_addr == `DIO_CO_CLR_LO);
  wire            wr_cfg = coil_wr && (
                    (coil_addr == `DIO_CO_LATCH_EN) ||
                    hit_any(coil_addr, `DIO_CO_CNT_EN, N_DI) ||
                    hit_any(coil_addr, `DIO_CO_FREQ_EN, N_DI) ||
                    hit_any(coil_addr, `DIO_CO_POWERON, N_DO) ||
                    hit_any(coil_addr, `DIO_CO_SAFE, N_DO));

  ////////////////////////////////////////////////////////////////////////
  // input synchroniser; only the second stage feeds logic

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      din_s1_r <= {N_DI{1'b0}};
      din_s2_r <= {N_DI{1'b0}};
      din_prev_r <= {N_DI{1'b0}};
    end else begin
      din_s1_r <= din;
      din_s2_r <= din_s1_r;
      din_prev_r <= din_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration coils, flash requests

  always @(posedge clk_sys or posedge rst) begin : p_cfg
    integer i;
    if (rst) begin
      pwm_en_r <= {N_DO{`DIO_RST_PWM_EN}};
      cfg_latch_en_r <= `DIO_RST_LATCH_EN;
      cfg_cnt_en_r <= {N_DI{`DIO_RST_CNT_EN}};
      cfg_freq_en_r <= {N_DI{`DIO_RST_FREQ_EN}};
      cfg_poweron_r <= {N_DO{`DIO_RST_POWERON}};
      cfg_safe_r <= {N_DO{`DIO_RST_SAFE}};
      flash_save_req_r <= 1'b0;
      flash_auto_req_r <= 1'b0;
    end else begin
      // saved-on-command data leaves only through this pulse
      flash_save_req_r <= coil_wr && coil_wdata &&
                          (coil_addr == `DIO_CO_SAVE);
      flash_auto_req_r <= wr_cfg;
      if (flash_restore) begin
        cfg_latch_en_r <= flash_latch_en;
        cfg_cnt_en_r <= flash_cnt_en;
        cfg_freq_en_r <= flash_freq_en;
        cfg_poweron_r <= flash_poweron;
        cfg_safe_r <= flash_safe;
      end else if (coil_wr) begin
        if (coil_addr == `DIO_CO_LATCH_EN)
          cfg_latch_en_r <= coil_wdata;
        for (i = 0; i < N_DO; i = i + 1) begin
          if (hit(coil_addr, `DIO_CO_PWM_EN, i))
            pwm_en_r[i] <= coil_wdata;
          if (hit(coil_addr, `DIO_CO_POWERON, i))
            cfg_poweron_r[i] <= coil_wdata;
          if (hit(coil_addr, `DIO_CO_SAFE, i))
            cfg_safe_r[i] <= coil_wdata;
        end
        for (i = 0; i < N_DI; i = i + 1) begin
          if (hit(coil_addr, `DIO_CO_CNT_EN, i))
            cfg_cnt_en_r[i] <= coil_wdata;
          if (hit(coil_addr, `DIO_CO_FREQ_EN, i))
            cfg_freq_en_r[i] <= coil_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs and host link watchdog

  always @(posedge clk_sys or posedge rst) begin : p_out
    integer i;
    if (rst) begin
      sec_div_r <= 32'h00000000;
      wdt_sec_r <= 17'h00000;
      wdt_tripped_r <= 1'b0;
      wdt_event_count_r <= 16'h0000;
      out_state_r <= {N_DO{`DIO_RST_POWERON}};
    end else begin
      if (host_activity || sec_tick)
        sec_div_r <= 32'h00000000;
      else
        sec_div_r <= sec_div_r + 32'h00000001;
      if (host_activity) begin
        wdt_sec_r <= 17'h00000;
        wdt_tripped_r <= 1'b0;
      end else if (wdt_fire) begin
        wdt_tripped_r <= 1'b1;
        wdt_event_count_r <= wdt_event_count_r + 16'h0001;
      end else if (sec_tick && wdt_sec_r != 17'h1ffff) begin
        wdt_sec_r <= wdt_sec_r + 17'h00001;
      end
      // a coil write in the trip cycle outranks the safe-state load; the trip is still counted
      if (flash_restore)
        out_state_r <= flash_poweron;
      else if (wdt_fire && !coil_wr)
        out_state_r <= cfg_safe_r;
      else if (coil_wr) begin
        for (i = 0; i < N_DO; i = i + 1)
          if (hit(coil_addr, `DIO_CO_OUT, i))
            out_state_r[i] <= coil_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm, starts with the high phase; a zero high width keeps the output low, a zero low width still lasts one ms

  always @(posedge clk_sys or posedge rst) begin : p_pwm
    integer i;
    if (rst) begin
      ms_div_r <= 32'h00000000;
      pwm_phase_r <= {N_DO{1'b1}};
      for (i = 0; i < N_DO; i = i + 1)
        pwm_cnt_r[i] <= 16'h0000;
    end else begin
      ms_div_r <= ms_tick ? 32'h00000000 : ms_div_r + 32'h00000001;
      for (i = 0; i < N_DO; i = i + 1) begin
        if (!pwm_en_r[i]) begin
          pwm_phase_r[i] <= 1'b1;
          pwm_cnt_r[i] <= 16'h0000;
        end else if (ms_tick) begin
          if (pwm_cnt_r[i] + 16'h0001 >= (pwm_phase_r[i] ?
              pwm_high_ms[16*i +: 16] : pwm_low_ms[16*i +: 16])) begin
            pwm_phase_r[i] <= !pwm_phase_r[i];
            pwm_cnt_r[i] <= 16'h0000;
          end else
            pwm_cnt_r[i] <= pwm_cnt_r[i] + 16'h0001;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_DO; g = g + 1) begin : g_out
      assign dout[g] = pwm_en_r[g] ?
        (pwm_phase_r[g] && pwm_high_ms[16*g +: 16] != 16'h0000) :
        out_state_r[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // latches, counters, frequency

  always @(posedge clk_sys or posedge rst) begin : p_in
    integer i;
    if (rst) begin
      hi_latch_r <= {N_DI{1'b0}};
      lo_latch_r <= {N_DI{1'b0}};
      gate_div_r <= 32'h00000000;
      for (i = 0; i < N_DI; i = i + 1) begin
        cnt_r[i] <= 32'h00000000;
        freq_acc_r[i] <= 32'h00000000;
        freq_val_r[i] <= 32'h00000000;
      end
    end else begin
      // capture in the clear cycle still sets the latch
      hi_latch_r <= (wr_clr_hi ? {N_DI{1'b0}} : hi_latch_r) |
                    (cfg_latch_en_r ? din_s2_r : {N_DI{1'b0}});
      lo_latch_r <= (wr_clr_lo ? {N_DI{1'b0}} : lo_latch_r) |
                    (cfg_latch_en_r ? ~din_s2_r : {N_DI{1'b0}});
      gate_div_r <= gate_end ? 32'h00000000 : gate_div_r + 32'h00000001;
      for (i = 0; i < N_DI; i = i + 1) begin
        if (coil_wr && coil_wdata && hit(coil_addr, `DIO_CO_CLR_CNT, i))
          cnt_r[i] <= 32'h00000000;
        else if (cfg_cnt_en_r[i] && rise[i])
          cnt_r[i] <= cnt_r[i] + 32'h00000001;
        // one-second gate, so edges times scale is hz times 1000
        if (!cfg_freq_en_r[i]) begin
          freq_acc_r[i] <= 32'h00000000;
          freq_val_r[i] <= 32'h00000000;
        end else if (gate_end) begin
          freq_val_r[i] <= (freq_acc_r[i] + {31'h0, rise[i]}) *
                           `DIO_FREQ_SCALE;
          freq_acc_r[i] <= 32'h00000000;
        end else if (rise[i])
          freq_acc_r[i] <= freq_acc_r[i] + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read answers, one cycle after the strobe; unmapped reads give 0

  reg        coil_rd_nxt;
  reg        di_rd_nxt;
  reg [15:0] ir_rd_nxt;

  always @* begin : p_rd
    integer i;
    i = 0;
    coil_rd_nxt = 1'b0;
    di_rd_nxt = 1'b0;
    ir_rd_nxt = 16'h0000;
    if (coil_addr == `DIO_CO_LATCH_EN)
      coil_rd_nxt = cfg_latch_en_r;
    for (i = 0; i < N_DO; i = i + 1) begin
      if (hit(coil_addr, `DIO_CO_OUT, i))
        coil_rd_nxt = out_state_r[i];
      if (hit(coil_addr, `DIO_CO_PWM_EN, i))
        coil_rd_nxt = pwm_en_r[i];
      if (hit(coil_addr, `DIO_CO_POWERON, i))
        coil_rd_nxt = cfg_poweron_r[i];
      if (hit(coil_addr, `DIO_CO_SAFE, i))
        coil_rd_nxt = cfg_safe_r[i];
    end
    for (i = 0; i < N_DI; i = i + 1) begin
      if (hit(coil_addr, `DIO_CO_CNT_EN, i))
        coil_rd_nxt = cfg_cnt_en_r[i];
      if (hit(coil_addr, `DIO_CO_FREQ_EN, i))
        coil_rd_nxt = cfg_freq_en_r[i];
      if (hit(di_addr, `DIO_DI_STATUS, i))
        di_rd_nxt = din_s2_r[i];
      if (hit(di_addr, `DIO_DI_HI_LATCH, i))
        di_rd_nxt = hi_latch_r[i];
      if (hit(di_addr, `DIO_DI_LO_LATCH, i))
        di_rd_nxt = lo_latch_r[i];
      // low word at the even address, high word after it
      if (hit(ir_addr, `DIO_IR_COUNTER, 2*i))
        ir_rd_nxt = cnt_r[i][15:0];
      if (hit(ir_addr, `DIO_IR_COUNTER, 2*i+1))
        ir_rd_nxt = cnt_r[i][31:16];
      if (hit(ir_addr, `DIO_IR_FREQ, 2*i))
        ir_rd_nxt = freq_val_r[i][15:0];
      if (hit(ir_addr, `DIO_IR_FREQ, 2*i+1))
        ir_rd_nxt = freq_val_r[i][31:16];
    end
    if (ir_addr == `DIO_IR_N_DI)
      ir_rd_nxt = N_DI[15:0];
    if (ir_addr == `DIO_IR_N_DO)
      ir_rd_nxt = N_DO[15:0];
    if (ir_addr == `DIO_IR_N_CNT)
      ir_rd_nxt = N_DI[15:0];
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      coil_rdata_r <= 1'b0;
      coil_rvalid_r <= 1'b0;
      di_rdata_r <= 1'b0;
      di_rvalid_r <= 1'b0;
      ir_rdata_r <= 16'h0000;
      ir_rvalid_r <= 1'b0;
    end else begin
      coil_rvalid_r <= coil_rd;
      di_rvalid_r <= di_rd;
      ir_rvalid_r <= ir_rd;
      if (coil_rd)
        coil_rdata_r <= coil_rd_nxt;
      if (di_rd)
        di_rdata_r <= di_rd_nxt;
      if (ir_rd)
        ir_rdata_r <= ir_rd_nxt;
    end
  end

endmodule // dio_modbus_map

`default_nettype wire

// ### tb/dio_chk.sv
// checker for the modbus register bank, bound to its ports
// assumes one clock domain and the strobe contract of the bank
`timescale 1ns/100ps
`default_nettype none
`include "dio_defs.vh"
module dio_chk #(
  parameter N_DI = 6,
  parameter N_DO = 6
) (
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic            coil_wr,
  input wire logic [15:0]     coil_addr,
  input wire logic            coil_wdata,
  input wire logic            di_rd,
  input wire logic            di_rvalid_r,
  input wire logic            ir_rd,
  input wire logic [15:0]     ir_addr,
  input wire logic [15:0]     ir_rdata_r,
  input wire logic            ir_rvalid_r,
  input wire logic [N_DO-1:0] dout,
  input wire logic [15:0]     wdt_event_count_r,
  input wire logic            flash_save_req_r,
  input wire logic            flash_auto_req_r,
  input wire logic            flash_restore,
  input wire logic            cfg_latch_en_r,
  input wire logic [N_DI-1:0] cfg_cnt_en_r,
  input wire logic [N_DO-1:0] cfg_safe_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic save_d1_r;
  logic save_d2_r;
  // the save pulse may trail its write by one or two cycles
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      save_d1_r <= 1'b0;
      save_d2_r <= 1'b0;
    end else begin
      save_d1_r <= coil_wr && coil_addr == `DIO_CO_SAVE && coil_wdata;
      save_d2_r <= save_d1_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  out_coil_a: assert property (
    coil_wr && coil_addr == 16'h0 && !flash_restore |=>
    dout[0] == $past(coil_wdata)) else $error("output coil not followed");
  save_pulse_a: assert property (
    coil_wr && coil_addr == `DIO_CO_SAVE && coil_wdata |->
    ##[1:2] flash_save_req_r) else $error("save request missing");
  save_only_a: assert property (
    flash_save_req_r |-> save_d1_r || save_d2_r)
    else $error("save request without save coil");
  auto_rec_a: assert property (
    coil_wr && coil_addr == `DIO_CO_LATCH_EN |-> ##[1:2] flash_auto_req_r)
    else $error("auto record request missing");
  latch_cfg_a: assert property (
    coil_wr && coil_addr == `DIO_CO_LATCH_EN && !flash_restore |=>
    cfg_latch_en_r == $past(coil_wdata)) else $error("latch enable wrong");
  cnt_cfg_a: assert property (
    coil_wr && coil_addr == `DIO_CO_CNT_EN && !flash_restore |=>
    cfg_cnt_en_r[0] == $past(coil_wdata)) else $error("counter enable wrong");
  safe_cfg_a: assert property (
    coil_wr && coil_addr == `DIO_CO_SAFE && !flash_restore |=>
    cfg_safe_r[0] == $past(coil_wdata)) else $error("safe value wrong");
  wdt_safe_a: assert property (
    $changed(wdt_event_count_r) && !$past(coil_wr) && !$past(flash_restore)
    |-> dout == cfg_safe_r) else $error("trip without safe outputs");
  di_answer_a: assert property (
    di_rd |=> di_rvalid_r) else $error("discrete read unanswered");
  n_di_a: assert property (
    ir_rd && ir_addr == `DIO_IR_N_DI |=> ir_rvalid_r && ir_rdata_r == N_DI)
    else $error("input total wrong");
endmodule // dio_chk
bind dio_modbus_map dio_chk #(.N_DI(N_DI), .N_DO(N_DO)) i_chk (
  .clk_sys, .rst, .coil_wr, .coil_addr, .coil_wdata, .di_rd, .di_rvalid_r,
  .ir_rd, .ir_addr, .ir_rdata_r, .ir_rvalid_r, .dout, .wdt_event_count_r,
  .flash_save_req_r, .flash_auto_req_r, .flash_restore, .cfg_latch_en_r,
  .cfg_cnt_en_r, .cfg_safe_r);
`default_nettype wire

// ### tb/dio_host.sv
// client model: issues coil, discrete and input register accesses
// assumes strobes taken at a rising edge, answer one cycle later
`timescale 1ns/100ps
`default_nettype none
module dio_host (
  input  wire logic        clk_sys,
  output logic             coil_wr,
  output logic             coil_rd,
  output logic [15:0]      coil_addr,
  output logic             coil_wdata,
  output logic             di_rd,
  output logic [15:0]      di_addr,
  output logic             ir_rd,
  output logic [15:0]      ir_addr,
  output logic             host_activity,
  input  wire logic        coil_rdata_r,
  input  wire logic        di_rdata_r,
  input  wire logic [15:0] ir_rdata_r
);
  initial begin
    {coil_wr, coil_rd, di_rd, ir_rd, host_activity, coil_wdata} = '0;
    {coil_addr, di_addr, ir_addr} = '1;
  end
  // sel 0 write coil, 1 read coil, 2 read discrete, 3 read register
  task automatic access(input int sel, input logic [15:0] a,
                        input logic d, output logic [15:0] q);
    @(posedge clk_sys);
    coil_wr <= (sel == 0);
    coil_rd <= (sel == 1);
    di_rd <= (sel == 2);
    ir_rd <= (sel == 3);
    host_activity <= 1'b1;
    {coil_addr, di_addr, ir_addr} <= {a, a, a};
    coil_wdata <= d;
    @(posedge clk_sys);
    {coil_wr, coil_rd, di_rd, ir_rd, host_activity} <= '0;
    // released lines show garbage, never the last value
    {coil_addr, di_addr, ir_addr} <= {~a, ~a, ~a};
    coil_wdata <= ~d;
    #1;
    q = (sel == 1) ? {15'h0, coil_rdata_r} :
        (sel == 2) ? {15'h0, di_rdata_r} : ir_rdata_r;
  endtask
endmodule // dio_host
`default_nettype wire

// ### tb/test_dio_modbus_map.sv
// self-checking bench for the modbus register bank
// assumes dio_host as client; ms is 4 cycles, second 20 cycles
`timescale 1ns/100ps
`default_nettype none
module test_dio_modbus_map;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  din = 6'h00;
  logic [95:0] pwm_high_ms = '0;
  logic [95:0] pwm_low_ms = '0;
  logic [15:0] host_link_watchdog_s = 16'h0000;
  logic        flash_restore = 1'b0;
  logic [5:0]  flash_poweron = 6'h00;
  logic [5:0]  flash_safe = 6'h00;
  logic [5:0]  flash_freq_en = 6'h00;
  wire logic   coil_wr, coil_rd, coil_wdata, di_rd, ir_rd, host_activity;
  wire logic   coil_rdata_r, coil_rvalid_r, di_rdata_r, di_rvalid_r;
  wire logic   ir_rvalid_r, flash_save_req_r, flash_auto_req_r;
  wire logic   cfg_latch_en_r;
  wire logic [15:0] coil_addr, di_addr, ir_addr, ir_rdata_r;
  wire logic [15:0] wdt_event_count_r;
  wire logic [5:0]  dout, cfg_cnt_en_r, cfg_freq_en_r, cfg_poweron_r;
  wire logic [5:0]  cfg_safe_r;
  int          fail_count = 0;
  int          num_checks = 0;
  int          n_save = 0;
  int          n_auto = 0;
  logic [15:0] q;

  dio_modbus_map #(.MS_CYCLES(4), .SEC_CYCLES(20)) i_dut (
    .clk_sys, .rst, .coil_wr, .coil_rd, .coil_addr, .coil_wdata,
    .coil_rdata_r, .coil_rvalid_r, .di_rd, .di_addr, .di_rdata_r,
    .di_rvalid_r, .ir_rd, .ir_addr, .ir_rdata_r, .ir_rvalid_r, .din,
    .dout, .pwm_high_ms, .pwm_low_ms, .host_activity,
    .host_link_watchdog_s, .wdt_event_count_r, .flash_save_req_r,
    .flash_auto_req_r, .flash_restore, .flash_latch_en(1'b0),
    .flash_cnt_en(6'h00), .flash_freq_en, .flash_poweron,
    .flash_safe, .cfg_latch_en_r, .cfg_cnt_en_r, .cfg_freq_en_r,
    .cfg_poweron_r, .cfg_safe_r);
  dio_host i_host (
    .clk_sys, .coil_wr, .coil_rd, .coil_addr, .coil_wdata, .di_rd,
    .di_addr, .ir_rd, .ir_addr, .host_activity, .coil_rdata_r,
    .di_rdata_r, .ir_rdata_r);

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (flash_save_req_r)
      n_save <= n_save + 1;
    if (flash_auto_req_r)
      n_auto <= n_auto + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cw(logic [15:0] a, logic d);
    i_host.access(0, a, d, q);
  endtask
  task automatic rdc(int sel, logic [15:0] a, string nm, logic [31:0] e);
    logic v;
    i_host.access(sel, a, 1'b0, q);
    v = (sel == 1) ? coil_rvalid_r : (sel == 2) ? di_rvalid_r : ir_rvalid_r;
    chk("rvalid", 1, v);
    chk(nm, e, {16'h0, q});
  endtask
  task automatic pins(logic [5:0] v, int n);
    @(posedge clk_sys);
    din <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(1, 16'h64, "pwm_en0", 0);
    rdc(1, 16'h96, "latch_en", 0);
    rdc(1, 16'h9c, "cnt_en5", 0);
    rdc(1, 16'hbe, "freq_en0", 0);
    rdc(1, 16'heb, "poweron0", 0);
    rdc(1, 16'h110, "safe5", 0);
    rdc(3, 16'h64, "n_di", 6);
    rdc(3, 16'h6e, "n_do", 6);
    rdc(3, 16'h79, "n_cnt", 6);
    $display("test reset done");
  endtask
  task automatic t_outputs();
    for (int k = 0; k < 6; k += 2)
      cw(k[15:0], 1'b1);
    chk("dout", 6'h15, dout);
    rdc(1, 16'h2, "coil2", 1);
    for (int k = 0; k < 6; k += 2)
      cw(k[15:0], 1'b0);
    chk("dout_off", 6'h00, dout);
    $display("test outputs done");
  endtask
  task automatic t_latch();
    cw(16'h96, 1'b1);
    pins(6'h05, 5);
    pins(6'h00, 5);
    rdc(2, 16'h00, "di0", 0);
    rdc(2, 16'h20, "hi0", 1);
    rdc(2, 16'h21, "hi1", 0);
    rdc(2, 16'h40, "lo0", 1);
    cw(16'h20, 1'b1);
    rdc(2, 16'h20, "hi0_clr", 0);
    pins(6'h3f, 5);
    cw(16'h21, 1'b1);
    rdc(2, 16'h41, "lo1_clr", 0);
    rdc(2, 16'h01, "di1", 1);
    $display("test latch done");
  endtask
  task automatic t_counter();
    cw(16'h98, 1'b1);
    repeat (3) begin
      pins(6'h00, 4);
      pins(6'h02, 4);
    end
    rdc(3, 16'h12, "cnt1_lo", 3);
    rdc(3, 16'h13, "cnt1_hi", 0);
    rdc(3, 16'h10, "cnt0", 0);
    cw(16'h23, 1'b1);
    rdc(3, 16'h12, "cnt1_clr", 0);
    $display("test counter done");
  endtask
  task automatic t_freq();
    cw(16'hbe, 1'b1);
    // square wave of four cycles: five rising edges in every full gate
    fork
      repeat (40) pins(din ^ 6'h01, 1);
      begin
        repeat (60) @(posedge clk_sys);
        rdc(3, 16'h40, "frq0_lo", 32'd5000);
        chk("frq0_hz", 5, {16'h0, q} / 1000);
        rdc(3, 16'h41, "frq0_hi", 0);
      end
    join
    cw(16'hbe, 1'b0);
    rdc(3, 16'h40, "frq0_off", 0);
    $display("test frequency done");
  endtask
  task automatic t_flash();
    int a0;
    a0 = n_auto;
    cw(16'h3c, 1'b0);
    cw(16'h00, 1'b0);
    repeat (3) @(posedge clk_sys);
    chk("save_none", 0, n_save);
    chk("auto_none", a0, n_auto);
    cw(16'h3c, 1'b1);
    cw(16'h10b, 1'b1);
    cw(16'h10d, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk("save_one", 1, n_save);
    chk("auto_two", a0 + 2, n_auto);
    chk("safe", 6'h05, cfg_safe_r);
    $display("test flash done");
  endtask
  task automatic t_wdt();
    @(posedge clk_sys);
    host_link_watchdog_s <= 16'd5;
    cw(16'h00, 1'b0);
    repeat (100) @(posedge clk_sys);
    chk("wdt_early", 0, wdt_event_count_r);
    repeat (60) @(posedge clk_sys);
    chk("wdt_trip", 1, wdt_event_count_r);
    chk("dout_safe", 6'h05, dout);
    repeat (160) @(posedge clk_sys);
    chk("wdt_once", 1, wdt_event_count_r);
    host_link_watchdog_s <= 16'd0;
    $display("test watchdog done");
  endtask
  task automatic t_restore();
    @(posedge clk_sys);
    flash_poweron <= 6'h2a;
    flash_safe <= 6'h05;
    flash_freq_en <= 6'h09;
    flash_restore <= 1'b1;
    @(posedge clk_sys);
    flash_restore <= 1'b0;
    #1;
    chk("dout_pon", 6'h2a, dout);
    chk("cfg_pon", 6'h2a, cfg_poweron_r);
    chk("cfg_freq", 6'h09, cfg_freq_en_r);
    chk("cfg_latch", 0, cfg_latch_en_r);
    rdc(1, 16'hec, "pon1", 1);
    $display("test restore done");
  endtask
  task automatic t_pwm();
    int h;
    h = 0;
    @(posedge clk_sys);
    pwm_high_ms[63:48] <= 16'd2;
    pwm_low_ms[63:48] <= 16'd1;
    cw(16'h67, 1'b1);
    repeat (12) @(posedge clk_sys);
    repeat (24) begin
      @(posedge clk_sys);
      #1;
      h += int'(dout[3] === 1'b1);
    end
    chk("pwm_high", 16, h);
    cw(16'h67, 1'b0);
    #1;
    chk("pwm_off", 1, dout[3]);
    $display("test pwm done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_outputs();
    t_latch();
    t_counter();
    t_freq();
    t_flash();
    t_wdt();
    t_restore();
    t_pwm();
    give_verdict();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end
endmodule // test_dio_modbus_map
`default_nettype wire
